// ---- motion_sensor_spi.sv ----
module motion_sensor_spi #(
  parameter int unsigned MOT_RST_CYC = motion_spi_pkg::MOT_RST_CYC,
  parameter int unsigned STDWN_CYC = motion_spi_pkg::STDWN_CYC,
  parameter int unsigned REST_EN_CYC = motion_spi_pkg::REST_EN_CYC,
  parameter int unsigned REST_DIS_CYC = motion_spi_pkg::REST_DIS_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic serialClk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic misoOut,
  output logic misoOe_n,
  output logic motion_n,
  input wire logic dispValid,
  input wire logic [7:0] dispX,
  input wire logic [7:0] dispY,
  output logic motionValid,
  output logic lowCurrent,
  output logic shutdownActive,
  output logic [1:0] forced_rest_enable_bits
);

  // ****************************************
  // link domain (serialClk)
  // ****************************************
  logic linkRst;
  logic [4:0] bitCnt_r;
  logic [6:0] shift_r;
  logic isRead_r;
  logic [6:0] rdAddr_r;
  logic rdTgl_r;
  logic [6:0] wrAddr_r;
  logic [7:0] wrData_r;
  logic wrTgl_r;
  logic [6:0] txSh_r;
  logic [7:0] rdData_r;

  // select high clears the port at once
  assign linkRst = chip_select_n | ~rstn;

  // bit counter and input shifter on rising edges
  always_ff @(posedge serialClk or posedge linkRst) begin
    if (linkRst) begin
      bitCnt_r <= 5'h00;
      shift_r <= 7'h00;
      isRead_r <= 1'b0;
    end else begin
      shift_r <= {shift_r[5:0], mosi};
      if (bitCnt_r != motion_spi_pkg::FRAME_DONE) begin
        bitCnt_r <= bitCnt_r + 5'h01;
      end
      if (bitCnt_r == motion_spi_pkg::ADDR_LAST_BIT) begin
        isRead_r <= ~shift_r[6];
      end
    end
  end

  // captured commands, kept across select so clk_sys can take them
  always_ff @(posedge serialClk or negedge rstn) begin
    if (!rstn) begin
      rdAddr_r <= 7'h00;
      rdTgl_r <= 1'b0;
      wrAddr_r <= 7'h00;
      wrData_r <= 8'h00;
      wrTgl_r <= 1'b0;
    end else if (!chip_select_n) begin
      if (bitCnt_r == motion_spi_pkg::ADDR_LAST_BIT) begin
        if (!shift_r[6]) begin
          rdAddr_r <= {shift_r[5:0], mosi};
          rdTgl_r <= ~rdTgl_r;
        end else begin
          wrAddr_r <= {shift_r[5:0], mosi};
        end
      end
      if (bitCnt_r == motion_spi_pkg::DATA_LAST_BIT && !isRead_r) begin
        wrData_r <= {shift_r, mosi};
        wrTgl_r <= ~wrTgl_r;
      end
    end
  end

  // output shifter on falling edges, rdData_r is steady by then
  always_ff @(negedge serialClk or posedge linkRst) begin
    if (linkRst) begin
      misoOut <= 1'b0;
      misoOe_n <= 1'b1;
      txSh_r <= 7'h00;
    end else if (isRead_r) begin
      if (bitCnt_r == motion_spi_pkg::DATA_FIRST) begin
        misoOut <= rdData_r[7];
        txSh_r <= rdData_r[6:0];
        misoOe_n <= 1'b0;
      end else if (bitCnt_r > motion_spi_pkg::DATA_FIRST) begin
        misoOut <= txSh_r[6];
        txSh_r <= {txSh_r[5:0], 1'b0};
      end
    end
  end

  // ****************************************
  // event crossing into clk_sys
  // ****************************************
  logic [2:0] rdSync_r;
  logic [2:0] wrSync_r;
  logic rdEvt;
  logic wrEvt;

  // two flops, third only for the edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdSync_r <= 3'h0;
      wrSync_r <= 3'h0;
    end else begin
      rdSync_r <= {rdSync_r[1:0], rdTgl_r};
      wrSync_r <= {wrSync_r[1:0], wrTgl_r};
    end
  end

  assign rdEvt = rdSync_r[2] ^ rdSync_r[1];
  assign wrEvt = wrSync_r[2] ^ wrSync_r[1];

  // ****************************************
  // register file and motion flag
  // ****************************************
  logic [7:0] deltaX_r;
  logic [7:0] deltaY_r;
  logic motionFlag_r;
  logic xRead_r;
  logic yRead_r;
  logic [1:0] restBits_r;
  logic wrMotion;
  logic wrReset;
  logic wrShdn;
  logic wrRest;
  logic rdX;
  logic rdY;
  logic dispTake;
  motion_spi_pkg::pwr_state_t state_r;

  assign wrMotion = wrEvt && wrAddr_r == motion_spi_pkg::MOTION_ADDR;
  assign wrReset = wrEvt && wrAddr_r == motion_spi_pkg::SOFT_RESET_ADDR
    && wrData_r == motion_spi_pkg::SOFT_RESET_VAL;
  assign wrShdn = wrEvt && wrAddr_r == motion_spi_pkg::SHUTDOWN_ADDR
    && wrData_r == motion_spi_pkg::SHUTDOWN_VAL;
  assign wrRest = wrEvt && wrAddr_r == motion_spi_pkg::REST_CTRL_ADDR;
  assign rdX = rdEvt && rdAddr_r == motion_spi_pkg::DELTA_X_ADDR;
  assign rdY = rdEvt && rdAddr_r == motion_spi_pkg::DELTA_Y_ADDR;
  assign dispTake = dispValid && motionValid;

  // displacement data from the tracking core
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      deltaX_r <= motion_spi_pkg::DELTA_RST;
      deltaY_r <= motion_spi_pkg::DELTA_RST;
    end else if (wrReset) begin
      deltaX_r <= motion_spi_pkg::DELTA_RST;
      deltaY_r <= motion_spi_pkg::DELTA_RST;
    end else if (dispTake) begin
      deltaX_r <= dispX;
      deltaY_r <= dispY;
    end
  end

  // motion flag: new data wins over any clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      motionFlag_r <= 1'b0;
      xRead_r <= 1'b0;
      yRead_r <= 1'b0;
    end else if (dispTake) begin
      motionFlag_r <= 1'b1;
      xRead_r <= 1'b0;
      yRead_r <= 1'b0;
    end else if (wrMotion || wrReset
      || ((xRead_r || rdX) && (yRead_r || rdY))) begin
      motionFlag_r <= 1'b0;
      xRead_r <= 1'b0;
      yRead_r <= 1'b0;
    end else begin
      xRead_r <= xRead_r | rdX;
      yRead_r <= yRead_r | rdY;
    end
  end

  // forced rest control bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      restBits_r <= motion_spi_pkg::REST_RST;
    end else if (wrReset) begin
      restBits_r <= motion_spi_pkg::REST_RST;
    end else if (wrRest && state_r != motion_spi_pkg::PWR_SHDN_WAIT
      && state_r != motion_spi_pkg::PWR_SHDN) begin
      restBits_r <= wrData_r[1:0];
    end
  end

  // read data staged on the address event, unmapped reads zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdData_r <= 8'h00;
    end else if (rdEvt) begin
      case (rdAddr_r)
        motion_spi_pkg::MOTION_ADDR:
          rdData_r <= {motionFlag_r, 7'h00};
        motion_spi_pkg::DELTA_X_ADDR: rdData_r <= deltaX_r;
        motion_spi_pkg::DELTA_Y_ADDR: rdData_r <= deltaY_r;
        motion_spi_pkg::REST_CTRL_ADDR: rdData_r <= {6'h00, restBits_r};
        default: rdData_r <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // power sequencing
  // ****************************************
  logic [31:0] timer_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= motion_spi_pkg::PWR_UNINIT;
      timer_r <= 32'h0000_0000;
    end else if (wrReset) begin
      state_r <= motion_spi_pkg::PWR_RST_WAIT;
      timer_r <= MOT_RST_CYC;
    end else begin
      if (timer_r != 32'h0000_0000) begin
        timer_r <= timer_r - 32'h0000_0001;
      end
      case (state_r)
        motion_spi_pkg::PWR_UNINIT: state_r <= state_r;
        motion_spi_pkg::PWR_RST_WAIT, motion_spi_pkg::PWR_WAKE_WAIT: begin
          if (timer_r <= 32'h0000_0001) begin
            state_r <= motion_spi_pkg::PWR_RUN;
          end
        end
        motion_spi_pkg::PWR_RUN: begin
          if (wrShdn) begin
            state_r <= motion_spi_pkg::PWR_SHDN_WAIT;
            timer_r <= STDWN_CYC;
          end else if (wrRest && wrData_r[1:0] != 2'h0) begin
            state_r <= motion_spi_pkg::PWR_REST_WAIT;
            timer_r <= REST_EN_CYC;
          end
        end
        motion_spi_pkg::PWR_SHDN_WAIT: begin
          if (timer_r <= 32'h0000_0001) begin
            state_r <= motion_spi_pkg::PWR_SHDN;
          end
        end
        motion_spi_pkg::PWR_SHDN: state_r <= state_r;
        motion_spi_pkg::PWR_REST_WAIT, motion_spi_pkg::PWR_REST: begin
          if (wrShdn) begin
            state_r <= motion_spi_pkg::PWR_SHDN_WAIT;
            timer_r <= STDWN_CYC;
          end else if (wrRest && wrData_r[1:0] == 2'h0) begin
            state_r <= motion_spi_pkg::PWR_WAKE_WAIT;
            timer_r <= REST_DIS_CYC;
          end else if (state_r == motion_spi_pkg::PWR_REST_WAIT
            && timer_r <= 32'h0000_0001) begin
            state_r <= motion_spi_pkg::PWR_REST;
          end
        end
        default: state_r <= motion_spi_pkg::PWR_UNINIT;
      endcase
    end
  end

  // status levels from registered state
  assign motionValid = state_r == motion_spi_pkg::PWR_RUN;
  assign lowCurrent = state_r == motion_spi_pkg::PWR_SHDN
    || state_r == motion_spi_pkg::PWR_REST;
  assign shutdownActive = state_r == motion_spi_pkg::PWR_SHDN_WAIT
    || state_r == motion_spi_pkg::PWR_SHDN;
  assign forced_rest_enable_bits = restBits_r;
  assign motion_n = ~motionFlag_r;

endmodule : motion_sensor_spi

// ---- motion_spi_pkg.sv ----
package motion_spi_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_KHZ = 50000;      // clk_sys rate in kHz
  localparam int unsigned MOT_RST_MS = 23;      // soft reset to valid motion
  localparam int unsigned STDWN_MS = 50;        // shutdown to low current
  localparam int unsigned REST_EN_MS = 1000;    // rest enable to low current
  localparam int unsigned REST_DIS_MS = 1000;   // rest clear to valid motion
  // longest times round down: whole cycles inside the bound
  localparam int unsigned MOT_RST_CYC = MOT_RST_MS * CLK_KHZ;
  localparam int unsigned STDWN_CYC = STDWN_MS * CLK_KHZ;
  localparam int unsigned REST_EN_CYC = REST_EN_MS * CLK_KHZ;
  localparam int unsigned REST_DIS_CYC = REST_DIS_MS * CLK_KHZ;
  localparam int unsigned TIMER_W = 32;

  // ****************************************
  // serial frame layout
  // ****************************************
  localparam int unsigned DATA_W = 8;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h07;  // count at last address bit
  localparam logic [4:0] DATA_LAST_BIT = 5'h0f;  // count at last data bit
  localparam logic [4:0] DATA_FIRST = 5'h08;     // count before first data bit
  localparam logic [4:0] FRAME_DONE = 5'h10;     // saturated count

  // ****************************************
  // register offsets and command values
  // ****************************************
  localparam logic [6:0] MOTION_ADDR = 7'h02;
  localparam logic [6:0] DELTA_X_ADDR = 7'h03;
  localparam logic [6:0] DELTA_Y_ADDR = 7'h04;
  localparam logic [6:0] REST_CTRL_ADDR = 7'h20;
  localparam logic [6:0] SOFT_RESET_ADDR = 7'h3a;
  localparam logic [6:0] SHUTDOWN_ADDR = 7'h3b;
  localparam logic [7:0] SOFT_RESET_VAL = 8'h5a;
  localparam logic [7:0] SHUTDOWN_VAL = 8'he7;
  localparam int unsigned MOTION_FLAG_BIT = 7;
  localparam int unsigned REST_BITS_W = 2;      // forced_rest_enable_bits
  localparam logic [7:0] DELTA_RST = 8'h00;
  localparam logic [1:0] REST_RST = 2'h0;

  // ****************************************
  // power states
  // ****************************************
  typedef enum logic [2:0] {
    PWR_UNINIT = 3'b000,
    PWR_RST_WAIT = 3'b001,
    PWR_RUN = 3'b010,
    PWR_SHDN_WAIT = 3'b011,
    PWR_SHDN = 3'b100,
    PWR_REST_WAIT = 3'b101,
    PWR_REST = 3'b110,
    PWR_WAKE_WAIT = 3'b111
  } pwr_state_t;

endpackage : motion_spi_pkg

// ---- motion_sensor_spi_properties.sv ----
module motion_sensor_spi_properties #(
  parameter int unsigned STDWN_CYC = 1,
  parameter int unsigned REST_EN_CYC = 1,
  parameter int unsigned REST_DIS_CYC = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic chip_select_n,
  input wire logic misoOe_n,
  input wire logic motion_n,
  input wire logic dispValid,
  input wire logic motionValid,
  input wire logic lowCurrent,
  input wire logic shutdownActive,
  input wire logic [1:0] forced_rest_enable_bits
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  int unsigned shdnCnt_r, restCnt_r, wakeCnt_r;
  // select held high for two samples
  sequence selHigh;
    chip_select_n ##1 chip_select_n;
  endsequence
  // cycles spent in the shutdown, rest entry and wake waits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shdnCnt_r <= 0;
      restCnt_r <= 0;
      wakeCnt_r <= 0;
    end else begin
      shdnCnt_r <= (shutdownActive && !lowCurrent) ? shdnCnt_r + 1 : 0;
      restCnt_r <= (forced_rest_enable_bits != 2'h0 && !lowCurrent &&
                    !shutdownActive) ? restCnt_r + 1 : 0;
      if (motionValid || lowCurrent || shutdownActive)
        wakeCnt_r <= 0;
      else if (wakeCnt_r != 0 || $fell(lowCurrent))
        wakeCnt_r <= wakeCnt_r + 1;
    end
  end
  chk_oe_release: assert property (selHigh |-> misoOe_n)
    else $error("data out driven while deselected");
  chk_motion_set: assert property (
    dispValid && motionValid |=> !motion_n)
    else $error("motion pin not lowered");
  chk_motion_cause: assert property (
    $fell(motion_n) |-> $past(dispValid) && $past(motionValid))
    else $error("motion pin lowered without data");
  chk_clear_cause: assert property (
    $rose(motion_n) |-> !($past(dispValid) && $past(motionValid)))
    else $error("new data lost to a clear");
  chk_shdn_bound: assert property (shdnCnt_r <= STDWN_CYC + 1)
    else $error("shutdown too slow");
  chk_rest_bound: assert property (restCnt_r <= REST_EN_CYC + 1)
    else $error("rest entry too slow");
  chk_wake_bound: assert property (wakeCnt_r <= REST_DIS_CYC + 1)
    else $error("wake too slow");
  chk_low_idle: assert property (lowCurrent |-> !motionValid)
    else $error("motion valid in low current");
endmodule : motion_sensor_spi_properties

bind motion_sensor_spi motion_sensor_spi_properties #(
  .STDWN_CYC(STDWN_CYC), .REST_EN_CYC(REST_EN_CYC),
  .REST_DIS_CYC(REST_DIS_CYC)
) chk (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .chip_select_n(chip_select_n),
  .misoOe_n(misoOe_n),
  .motion_n(motion_n),
  .dispValid(dispValid),
  .motionValid(motionValid),
  .lowCurrent(lowCurrent),
  .shutdownActive(shutdownActive),
  .forced_rest_enable_bits(forced_rest_enable_bits)
);

// ---- spi_host_model.sv ----
module spi_host_model (
  output logic serialClk,
  output logic chip_select_n,
  output logic mosi,
  input wire logic misoOut,
  input wire logic misoOe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: clock high, deselected
  initial begin
    serialClk = 1'b1;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  // one frame of n bits: drive on fall, sample on rise
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      input int n, output logic [7:0] q);
    logic [15:0] sh;
    sh = {a, d};
    q = 'x;
    chip_select_n = 1'b0;
    mosi = sh[15];
    #120;
    // idle clock is high: every bit needs its own fall before its rise
    for (int i = 0; i < n; i++) begin
      if (i == 8 && !a[7])
        #4000;
      serialClk = 1'b0;
      mosi = sh[15 - i];
      #7.5;
      serialClk = 1'b1;
      if (i > 7)
        q[15 - i] = misoOe_n ? 1'bx : misoOut;
      #7.5;
    end
    #(a[7] ? 20000 : 120);
    chip_select_n = 1'b1;
    mosi = ~mosi;
    #(a[7] ? 30000 : 500);
  endtask : xfer
endmodule : spi_host_model

// ---- test_motion_sensor_spi.sv ----
module test_motion_sensor_spi;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic dispValid = 1'b0;
  logic [7:0] dispX = 8'h00;
  logic [7:0] dispY = 8'h00;
  logic serialClk, chip_select_n, mosi, misoOut, misoOe_n, motion_n;
  logic motionValid, lowCurrent, shutdownActive;
  logic [1:0] restBits;
  logic [7:0] q;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int expX, expY;
  motion_sensor_spi #(
    .MOT_RST_CYC(60), .STDWN_CYC(80), .REST_EN_CYC(100), .REST_DIS_CYC(120)
  ) dut (
    .clk_sys(clk_sys), .rstn(rstn), .serialClk(serialClk),
    .chip_select_n(chip_select_n), .mosi(mosi), .misoOut(misoOut),
    .misoOe_n(misoOe_n), .motion_n(motion_n), .dispValid(dispValid),
    .dispX(dispX), .dispY(dispY), .motionValid(motionValid),
    .lowCurrent(lowCurrent), .shutdownActive(shutdownActive),
    .forced_rest_enable_bits(restBits)
  );
  spi_host_model host (
    .serialClk(serialClk), .chip_select_n(chip_select_n), .mosi(mosi),
    .misoOut(misoOut), .misoOe_n(misoOe_n)
  );
  always #10 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a}, d, 16, q);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    host.xfer({1'b0, a}, 8'h00, 16, q);
  endtask : rd
  // one-cycle displacement report from the tracking core
  task automatic pulse(input logic [7:0] x, y);
    @(posedge clk_sys);
    dispValid <= 1'b1;
    dispX <= x;
    dispY <= y;
    @(posedge clk_sys);
    dispValid <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : pulse
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(82469));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("motionValid", 8'(motionValid), 8'h00);
    chk("misoOe_n", 8'(misoOe_n), 8'h01);
    wr(7'h3a, 8'h5a);
    chk("motionValid", 8'(motionValid), 8'h01);
    for (int k = 0; k < 3; k++) begin
      expX = $urandom_range(255);
      expY = $urandom_range(255);
      pulse(8'(expX), 8'(expY));
      chk("motion_n", 8'(motion_n), 8'h00);
      rd(7'h02);
      chk("flag", 8'(q[7]), 8'h01);
      rd(k[0] ? 7'h04 : 7'h03);
      chk("delta", q, 8'(k[0] ? expY : expX));
      chk("motion_n", 8'(motion_n), 8'h00);
      rd(k[0] ? 7'h03 : 7'h04);
      chk("delta", q, 8'(k[0] ? expX : expY));
      chk("motion_n", 8'(motion_n), 8'h01);
      chk("misoOe_n", 8'(misoOe_n), 8'h01);
    end
    pulse(8'h11, 8'h22);
    host.xfer(8'h82, 8'h00, 12, q);
    chk("motion_n", 8'(motion_n), 8'h00);
    wr(7'h02, 8'h00);
    chk("motion_n", 8'(motion_n), 8'h01);
    rd(7'h7f);
    chk("unmapped", q, 8'h00);
    wr(7'h20, 8'h03);
    chk("rest", 8'(restBits), 8'h03);
    chk("lowCurrent", 8'(lowCurrent), 8'h01);
    pulse(8'h05, 8'h06);
    chk("motion_n", 8'(motion_n), 8'h01);
    wr(7'h20, 8'h00);
    chk("motionValid", 8'(motionValid), 8'h01);
    wr(7'h3b, 8'he7);
    chk("shutdown", 8'(shutdownActive), 8'h01);
    chk("lowCurrent", 8'(lowCurrent), 8'h01);
    wr(7'h20, 8'h01);
    chk("rest", 8'(restBits), 8'h00);
    wr(7'h3a, 8'h5a);
    chk("shutdown", 8'(shutdownActive), 8'h00);
    chk("motionValid", 8'(motionValid), 8'h01);
    tally_and_finish();
  end
endmodule : test_motion_sensor_spi
